// ==== rtl/ddrwb_burst.sv ====
// Column burst engine of a x8 DDR3 device: write capture, read return.
// Assumes pins arrive asynchronous to clk_in and software uses APB.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
module ddrwb_burst (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Memory pins
  input wire logic ck_in,
  input ddrwb_pkg::ddrwb_cmd_t cmd_in,
  input wire logic dqs_in,
  input wire logic dm_in,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  output logic dqs_out,
  output logic dqs_oe_out
);
  import ddrwb_pkg::*;

  function automatic logic [3:0] beats(input logic [1:0] bl,
                                       input logic a12);
    if (bl == DDRWB_BL_FIX4) begin
      beats = DDRWB_BEATS4;
    end else if (bl == DDRWB_BL_OTF && !a12) begin
      beats = DDRWB_BEATS4;
    end else begin
      beats = DDRWB_BEATS8;
    end
  endfunction

  // Input synchronisers
  logic [1:0] ck_s_r, dqs_s_r;
  ddrwb_cmd_t cmd_m_r, cmd_s_r;
  logic [8:0] dat_m_r, dat_s_r;
  logic ck_d_r, dqs_d_r;
  always_ff @(posedge clk_in) begin
    ck_s_r <= {ck_s_r[0], ck_in};
    dqs_s_r <= {dqs_s_r[0], dqs_in};
    cmd_m_r <= cmd_in;
    cmd_s_r <= cmd_m_r;
    dat_m_r <= {dm_in, dq_in};
    dat_s_r <= dat_m_r;
    ck_d_r <= ck_s_r[1];
    dqs_d_r <= dqs_s_r[1];
  end
  logic ck_rise, ck_edge, dqs_edge;
  assign ck_rise = ck_s_r[1] & ~ck_d_r;
  assign ck_edge = ck_s_r[1] ^ ck_d_r;
  assign dqs_edge = dqs_s_r[1] ^ dqs_d_r;

  // Registers
  logic [15:0] cfg_r;
  logic [15:0] wcnt_r, rcnt_r;
  logic last_bc4_r;
  ddrwb_state_t st_r;
  logic [1:0] bl_set;
  logic tdqs_en;
  logic [3:0] cl, cwl, al;
  assign bl_set = cfg_r[DDRWB_BL_LSB +: 2];
  assign tdqs_en = cfg_r[DDRWB_TDQS_BIT];
  assign cl = cfg_r[DDRWB_CL_LSB +: 4];
  assign cwl = cfg_r[DDRWB_CWL_LSB +: 4];
  assign al = cfg_r[DDRWB_AL_LSB +: 4];

  logic apb_acc, apb_map;
  assign apb_acc = psel_in & penable_in & pready_out;
  assign apb_map = paddr_in == DDRWB_CFG_OFF || paddr_in == DDRWB_STAT_OFF ||
                   paddr_in == DDRWB_WCNT_OFF || paddr_in == DDRWB_RCNT_OFF;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~apb_map;
      case (paddr_in)
        DDRWB_CFG_OFF: prdata_out <= {16'h0000, cfg_r};
        DDRWB_STAT_OFF:
          prdata_out <= {26'h000_0000, st_r, last_bc4_r};
        DDRWB_WCNT_OFF: prdata_out <= {16'h0000, wcnt_r};
        DDRWB_RCNT_OFF: prdata_out <= {16'h0000, rcnt_r};
        default: prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cfg_r <= DDRWB_CFG_RST;
    end else if (apb_acc && pwrite_in && paddr_in == DDRWB_CFG_OFF) begin
      cfg_r <= pwdata_in[15:0];
    end
  end

  // Burst sequencer
  logic [7:0] mem [DDRWB_MEM_DEPTH];
  logic [3:0] len_r, beat_r;
  logic [4:0] lat_r, wdog_r;
  logic [2:0] ba_r;
  logic [2:0] colb_r;
  logic [3:0] cmd_code;
  logic [6:0] idx;
  assign cmd_code = {cmd_s_r.cs_n, cmd_s_r.ras_n, cmd_s_r.cas_n,
                     cmd_s_r.we_n};
  // Column low bits only; A12 stays out of the address
  assign idx = {ba_r, colb_r[2] & (len_r == DDRWB_BEATS4), beat_r[2:0]
               ^ {1'b0, colb_r[1:0]}};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= DDRWB_IDLE;
      len_r <= DDRWB_BEATS8;
      beat_r <= 4'h0;
      lat_r <= 5'h00;
      wdog_r <= 5'h00;
      ba_r <= 3'h0;
      colb_r <= 3'h0;
      last_bc4_r <= 1'b0;
      wcnt_r <= 16'h0000;
      rcnt_r <= 16'h0000;
    end else begin
      case (st_r)
        DDRWB_IDLE: begin
          beat_r <= 4'h0;
          if (ck_rise && (cmd_code == DDRWB_CMD_WRITE ||
                          cmd_code == DDRWB_CMD_READ)) begin
            len_r <= beats(bl_set, cmd_s_r.addr[DDRWB_OTF_BIT]);
            last_bc4_r <= beats(bl_set, cmd_s_r.addr[DDRWB_OTF_BIT])
                          == DDRWB_BEATS4;
            ba_r <= cmd_s_r.ba;
            colb_r <= cmd_s_r.addr[2:0];
            if (cmd_code == DDRWB_CMD_WRITE) begin
              lat_r <= 5'(al) + 5'(cwl);
              st_r <= DDRWB_WLAT;
            end else begin
              lat_r <= 5'(al) + 5'(cl);
              st_r <= DDRWB_RLAT;
            end
          end
        end
        DDRWB_WLAT: begin
          if (ck_rise) begin
            lat_r <= lat_r - 5'h01;
            // Open one CK early so the beat at CK rise WL is caught
            if (lat_r <= 5'h02) begin
              st_r <= DDRWB_WDAT;
              wdog_r <= 5'(len_r >> 1) + DDRWB_WR_SLACK;
            end
          end
        end
        DDRWB_WDAT: begin
          if (dqs_edge) begin
            beat_r <= beat_r + 4'h1;
          end
          if (ck_rise) begin
            wdog_r <= wdog_r - 5'h01;
          end
          // Missing strobes give up the burst instead of hanging
          if ((dqs_edge && beat_r + 4'h1 == len_r) ||
              (ck_rise && wdog_r == 5'h00)) begin
            st_r <= DDRWB_IDLE;
            wcnt_r <= wcnt_r + 16'h0001;
          end
        end
        DDRWB_RLAT: begin
          if (ck_rise) begin
            lat_r <= lat_r - 5'h01;
          end
          // Turn round on the fall before CK rise RL, beat 0 lands on it
          if (ck_edge && !ck_rise && lat_r <= 5'h01) begin
            st_r <= DDRWB_RDAT;
          end
        end
        DDRWB_RDAT: begin
          if (ck_edge) begin
            beat_r <= beat_r + 4'h1;
            if (beat_r == len_r) begin
              st_r <= DDRWB_IDLE;
              rcnt_r <= rcnt_r + 16'h0001;
            end
          end
        end
        default: st_r <= DDRWB_IDLE;
      endcase
    end
  end

  // Array write; mask ignored in TDQS mode and on reads
  always_ff @(posedge clk_in) begin
    if (st_r == DDRWB_WDAT && dqs_edge && beat_r < len_r &&
        !(dat_s_r[8] && !tdqs_en)) begin
      mem[idx] <= dat_s_r[7:0];
    end
  end

  // Read drive, one beat per CK edge
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dq_out <= 8'h00;
      dq_oe_out <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe_out <= 1'b0;
    end else if (st_r == DDRWB_RDAT && ck_edge) begin
      dq_oe_out <= beat_r < len_r;
      dqs_oe_out <= beat_r < len_r;
      dqs_out <= ~beat_r[0] & (beat_r < len_r);
      dq_out <= mem[idx];
    end else if (st_r != DDRWB_RDAT) begin
      dq_oe_out <= 1'b0;
      dqs_oe_out <= 1'b0;
      dqs_out <= 1'b0;
    end
  end
endmodule

// ==== rtl/ddrwb_pkg.sv ====
// Shared constants, types and register map of the burst engine.
// Assumes a 100 MHz system clock that samples the memory pins.
package ddrwb_pkg;
  // Register byte offsets
  localparam logic [7:0] DDRWB_CFG_OFF = 8'h00;
  localparam logic [7:0] DDRWB_STAT_OFF = 8'h04;
  localparam logic [7:0] DDRWB_WCNT_OFF = 8'h08;
  localparam logic [7:0] DDRWB_RCNT_OFF = 8'h0c;
  // Config fields
  localparam int DDRWB_BL_LSB = 0;
  localparam int DDRWB_TDQS_BIT = 2;
  localparam int DDRWB_CL_LSB = 4;
  localparam int DDRWB_CWL_LSB = 8;
  localparam int DDRWB_AL_LSB = 12;
  localparam logic [15:0] DDRWB_CFG_RST = 16'h0560;
  // Burst length settings
  localparam logic [1:0] DDRWB_BL_FIX8 = 2'b00;
  localparam logic [1:0] DDRWB_BL_OTF = 2'b01;
  localparam logic [1:0] DDRWB_BL_FIX4 = 2'b10;
  localparam logic [3:0] DDRWB_BEATS4 = 4'h4;
  localparam logic [3:0] DDRWB_BEATS8 = 4'h8;
  localparam int DDRWB_OTF_BIT = 12;
  // Spare CK cycles allowed before a write burst is abandoned
  localparam logic [4:0] DDRWB_WR_SLACK = 5'h02;
  localparam int DDRWB_MEM_DEPTH = 128;
  localparam logic [3:0] DDRWB_CMD_WRITE = 4'b0100;
  localparam logic [3:0] DDRWB_CMD_READ = 4'b0101;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } ddrwb_cmd_t;

  typedef enum logic [4:0] {
    DDRWB_IDLE = 5'b00001,
    DDRWB_WLAT = 5'b00010,
    DDRWB_WDAT = 5'b00100,
    DDRWB_RLAT = 5'b01000,
    DDRWB_RDAT = 5'b10000
  } ddrwb_state_t;
endpackage

// ==== testbench/ddrwb_ctl_model.sv ====
// Controller model: free-running CK, commands, centred write strobes.
// Assumes the device runs with AL 0 and CWL 5 after reset.
`timescale 1ns/10ps
module ddrwb_ctl_model #(parameter int WL = 5) (
  // Link outputs
  output ddrwb_pkg::ddrwb_cmd_t cmd_out,
  output logic ck_out,
  output logic dqs_out,
  output logic dm_out,
  output logic [7:0] dq_out
);
  import ddrwb_pkg::*;
  initial begin
    ck_out = 1'b0;
    dqs_out = 1'b0;
    dm_out = 1'b0;
    dq_out = 8'h00;
    cmd_out = '1;
  end
  always #40 ck_out = ~ck_out;
  // Column commands only, so bank timing is never at stake
  task automatic cmd_go(input logic [3:0] c, input logic [2:0] b,
      input logic a);
    @(negedge ck_out);
    cmd_out = {c, b, 1'b0, a, 12'h000};
    @(negedge ck_out);
    cmd_out = '1;
  endtask
  task automatic wr(input logic [2:0] b, input logic a,
      input logic [63:0] d, input logic [7:0] m, input int n);
    cmd_go(DDRWB_CMD_WRITE, b, a);
    repeat (WL - 1) @(posedge ck_out);
    #40;
    for (int i = 0; i < n; i++) begin
      #20 dq_out = d[8*i+:8];
      dm_out = m[i];
      #20 dqs_out = ~dqs_out;
    end
    #20 dq_out = ~dq_out;
    dm_out = ~dm_out;
    repeat (8) @(posedge ck_out);
  endtask
endmodule

// ==== testbench/ddrwb_burst_assertions.sv ====
// Checker on burst engine ports: APB handshake and read strobe.
// Assumes it is bound to every burst engine instance.
`timescale 1ns/10ps
module ddrwb_chk (
  // Clock, reset, APB
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Read pins
  input wire logic dq_oe_out,
  input wire logic dqs_out,
  input wire logic dqs_oe_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic bad;
  assign bad = paddr_in > 8'h0c || paddr_in[1:0] != 2'h0;
  a_rdy_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready long");
  a_rdy_late: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("ready late");
  a_rdy_req: assert property (pready_out |-> psel_in && penable_in)
    else $error("stray ready");
  a_err_bad: assert property (pready_out && bad |-> pslverr_out)
    else $error("no error");
  a_err_good: assert property (pready_out && !bad |-> !pslverr_out)
    else $error("false error");
  a_oe_pair: assert property (dq_oe_out |-> dqs_oe_out)
    else $error("no strobe");
  a_burst_min: assert property ($rose(dqs_oe_out) |-> dqs_oe_out[*8])
    else $error("short burst");
  a_beat_hold: assert property (dqs_oe_out && $changed(dqs_out)
    |=> $stable(dqs_out)[*2]) else $error("short beat");
  c_read: cover property ($rose(dqs_oe_out));
  c_err: cover property (pslverr_out);
  c_ok: cover property (pready_out && !pslverr_out);
endmodule
bind ddrwb_burst ddrwb_chk chk_u (.clk_in, .sys_rst_in, .psel_in,
  .penable_in, .paddr_in, .pready_out, .pslverr_out, .dq_oe_out,
  .dqs_out, .dqs_oe_out);

// ==== testbench/ddrwb_burst_tb.sv ====
// Testbench of the burst engine: APB registers and memory bursts.
// Assumes the controller model and checker compile first.
`timescale 1ns/10ps
module ddrwb_burst_tb;
  import ddrwb_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr, ck, dqs, dm;
  logic dq_oe, dqs_o, dqs_oe;
  logic [7:0] pa = 8'h00, dq, dq_o;
  logic [31:0] pwd = '0, prd;
  ddrwb_cmd_t cmd;
  int err_count = 0, n_compared = 0, cyc = 0;
  localparam logic [63:0] D8 = 64'h8877_6655_4433_2211;
  // First read beat after cmd_go returns: RL 6 CK, pin sync, out flop
  localparam int RD_DLY = 6 * 80 - 40 + 35;
  always #5 clk_in = ~clk_in;
  ddrwb_burst dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .ck_in(ck), .cmd_in(cmd), .dqs_in(dqs),
    .dm_in(dm), .dq_in(dq), .dq_out(dq_o), .dq_oe_out(dq_oe),
    .dqs_out(dqs_o), .dqs_oe_out(dqs_oe));
  ddrwb_ctl_model ctl_u (.cmd_out(cmd), .ck_out(ck), .dqs_out(dqs),
    .dm_out(dm), .dq_out(dq));
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] x, input logic xe);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    @(posedge clk_in iff prdy);
    if (!w) chk(prd, x);
    chk(32'(perr), 32'(xe));
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] b, input logic a,
      input logic [63:0] x, input int n);
    int k;
    logic p;
    logic [63:0] g;
    time t;
    k = 0;
    p = 1'b0;
    g = '0;
    ctl_u.cmd_go(DDRWB_CMD_READ, b, a);
    t = $time;
    @(posedge clk_in iff dqs_oe);
    chk(32'($time - t), 32'(RD_DLY));
    while (dqs_oe === 1'b1) begin
      if (k == 0 || dqs_o !== p) begin
        g[8*k+:8] = dq_o;
        k++;
      end
      p = dqs_o;
      @(posedge clk_in);
    end
    chk(32'(k), 32'(n));
    chk(g[63:32], x[63:32]);
    chk(g[31:0], x[31:0]);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    apb(0, DDRWB_CFG_OFF, '0, 32'h0000_0560, 0);
    apb(0, DDRWB_STAT_OFF, '0, 32'h0000_0002, 0);
    apb(0, 8'h10, '0, '0, 1);
    apb(1, DDRWB_STAT_OFF, 32'h0000_00ff, '0, 0);
    $display("registers done");
    ctl_u.wr(3'h1, 1, D8, 8'h00, 8);
    rd(3'h1, 1, D8, 8);
    $display("fixed eight done");
    apb(1, DDRWB_CFG_OFF, 32'h0000_0561, '0, 0);
    ctl_u.wr(3'h2, 1, D8, 8'h00, 8);
    ctl_u.wr(3'h2, 0, 64'h0000_0000_ddcc_bbaa, 8'h02, 4);
    rd(3'h2, 0, 64'h0000_0000_ddcc_22aa, 4);
    apb(0, DDRWB_STAT_OFF, '0, 32'h0000_0003, 0);
    $display("on the fly done");
    apb(1, DDRWB_CFG_OFF, 32'h0000_0566, '0, 0);
    ctl_u.wr(3'h3, 1, D8, 8'h00, 2);
    ctl_u.wr(3'h3, 1, 64'h0000_0000_f0e0_d0c0, 8'hff, 4);
    rd(3'h3, 1, 64'h0000_0000_f0e0_d0c0, 4);
    apb(0, DDRWB_WCNT_OFF, '0, 32'h0000_0005, 0);
    apb(0, DDRWB_RCNT_OFF, '0, 32'h0000_0003, 0);
    $display("chop and mask done");
    close_out;
  end
endmodule
